// [src/pcd_pkg.sv]
package pcd_pkg;
  localparam int PCD_PORT_W = 8;
  localparam int PCD_ADDR_W = 16;
  localparam int PCD_WIN_BYTES = 256;
  localparam int PCD_WIN_AW = 8;
  localparam logic [PCD_ADDR_W-1:0] PCD_BASE_RST = 16'h0000;
  localparam int PCD_BIT_STBY = 2;
  localparam int PCD_BIT_STAT = 3;
  localparam int PCD_BIT_ERR = 4;
  localparam int PCD_BIT_TDI = 5;
  localparam int PCD_BIT_TDO = 6;
  localparam int PCD_BIT_BE = 7;
  localparam int PCD_BIT_ALE = 0;
  localparam int PCD_BIT_CLK = 1;
  localparam int PCD_BIT_CS = 2;
  // per-pin function codes
  typedef enum logic [1:0] {
    PCD_FN_MCU = 2'b00,
    PCD_FN_PLD = 2'b01,
    PCD_FN_ALT = 2'b10,
    PCD_FN_ALT2 = 2'b11
  } pcd_fn_e;
  typedef enum logic [1:0] {
    PCD_HOST_MUX = 2'b00,
    PCD_HOST_XA = 2'b01,
    PCD_HOST_PAGE = 2'b10,
    PCD_HOST_NONMUX = 2'b11
  } pcd_host_e;
endpackage

// [src/pcd_addr_map.sv]
`timescale 1ns/10ps
module pcd_addr_map
  import pcd_pkg::*;
(
  input wire logic [1:0] host_mode,
  input wire logic [PCD_ADDR_W-1:0] addr,
  output logic [PCD_PORT_W-1:0] pa_addr,
  output logic [PCD_PORT_W-1:0] pb_addr,
  output logic [PCD_PORT_W-1:0] pa_addr_en,
  output logic [PCD_PORT_W-1:0] pb_addr_en
);
  always_comb
  begin
    pa_addr = '0;
    pb_addr = '0;
    pa_addr_en = '0;
    pb_addr_en = '0;
    case (pcd_host_e'(host_mode))
      PCD_HOST_XA:
      begin
        pa_addr[7:4] = addr[7:4];
        pb_addr[3:0] = addr[11:8];
        pa_addr_en = 8'hF0;
        pb_addr_en = 8'h0F;
      end
      PCD_HOST_PAGE:
      begin
        pb_addr = addr[15:8];
        pb_addr_en = 8'hFF;
      end
      PCD_HOST_NONMUX:
      begin
        pb_addr = addr[7:0];
        pb_addr_en = 8'hFF;
      end
      default:
      begin
        pa_addr[3:0] = addr[3:0];
        pb_addr = addr[7:0];
        pa_addr_en = 8'h0F;
        pb_addr_en = 8'hFF;
      end
    endcase
  end
endmodule // pcd_addr_map

// [src/pcd_pin_mux.sv]
`timescale 1ns/10ps
// Behaviour
// - each C/D pin: MCU input/output, PLD input, or its alternate function
// - port C outputs selectable per pin as push-pull or open-drain
// - C3 drives JTAG status or programming ready/busy
// - C4 battery indicator high on battery power, low otherwise
// - C4 JTAG error out, C5 TDI in, C6 TDO out when JTAG on
// - C2 may serve as SRAM standby supply input, no logic function
// - C7 may be active-low byte enable input driven by host
// - D0 may be address strobe; device latches multiplexed address on it
// - D1 may be external clock for power-down counter and AND array
// - D2 chip select: low allows access, high disables memories
// - generic mux host: addr 3:0 to A/B low, 7:4 to B high
// - XA, page and non-mux hosts use their own latched address mapping
// - registers sit in a 256-byte window at a user base address
// - active-low reset clears ports and latched address; held at power-up
module pcd_pin_mux
  import pcd_pkg::*;
#(
  parameter int PORT_W = PCD_PORT_W
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [2*PORT_W-1:0] pc_fn,
  input wire logic [2*PORT_W-1:0] pd_fn,
  input wire logic [PORT_W-1:0] pc_open_drain,
  input wire logic [PORT_W-1:0] pc_dir_out,
  input wire logic [PORT_W-1:0] pd_dir_out,
  input wire logic [PORT_W-1:0] pc_data_out,
  input wire logic [PORT_W-1:0] pd_data_out,
  input wire logic [1:0] host_mode,
  input wire logic jtag_enable,
  input wire logic jtag_prog_status_out,
  input wire logic jtag_prog_error_out,
  input wire logic jtag_tdo,
  input wire logic flash_ready,
  input wire logic on_battery,
  input wire logic [PCD_ADDR_W-1:0] bus_addr,
  input wire logic [PCD_ADDR_W-1:0] register_window_base,
  input wire logic [PORT_W-1:0] pc_in,
  input wire logic [PORT_W-1:0] pd_in,
  output logic [PORT_W-1:0] pc_out,
  output logic [PORT_W-1:0] pc_oe,
  output logic [PORT_W-1:0] pd_out,
  output logic [PORT_W-1:0] pd_oe,
  output logic [PORT_W-1:0] pc_data_in,
  output logic [PORT_W-1:0] pd_data_in,
  output logic [PORT_W-1:0] pc_pld_in,
  output logic [PORT_W-1:0] pd_pld_in,
  output logic jtag_tdi,
  output logic byte_enable_n,
  output logic aux_clock_input,
  output logic mem_enable,
  output logic window_hit,
  output logic [PCD_WIN_AW-1:0] window_offset,
  output logic [PORT_W-1:0] pa_addr_out,
  output logic [PORT_W-1:0] pb_addr_out,
  output logic [PORT_W-1:0] pa_addr_en,
  output logic [PORT_W-1:0] pb_addr_en
);
  import pcd_pkg::*;

  // two-stage synchronisers for all pin inputs
  logic [PORT_W-1:0] pc_m_q, pc_s_q, pd_m_q, pd_s_q;
  logic [PORT_W-1:0] pc_m_d, pc_s_d, pd_m_d, pd_s_d;
  logic ale_prev_q, ale_prev_d;
  logic [PCD_ADDR_W-1:0] lat_addr_q, lat_addr_d;
  logic [PORT_W-1:0] pc_out_q, pc_out_d, pc_oe_q, pc_oe_d;
  logic [PORT_W-1:0] pd_out_q, pd_out_d, pd_oe_q, pd_oe_d;
  logic [PORT_W-1:0] pc_din_q, pc_din_d, pd_din_q, pd_din_d;
  logic [PORT_W-1:0] pc_pld_q, pc_pld_d, pd_pld_q, pd_pld_d;
  logic tdi_q, tdi_d, be_q, be_d, clk_q, clk_d, men_q, men_d;
  logic hit_q, hit_d;
  logic [PCD_WIN_AW-1:0] off_q, off_d;
  logic [PORT_W-1:0] pa_a_q, pb_a_q, pa_e_q, pb_e_q;
  logic [PORT_W-1:0] pa_a_d, pb_a_d, pa_e_d, pb_e_d;
  logic [PCD_ADDR_W-1:0] rel_addr;

  pcd_addr_map u_map (
    .host_mode(host_mode),
    .addr(lat_addr_q),
    .pa_addr(pa_a_d),
    .pb_addr(pb_a_d),
    .pa_addr_en(pa_e_d),
    .pb_addr_en(pb_e_d)
  );

  function automatic pcd_fn_e fn_of(input logic [2*PCD_PORT_W-1:0] v,
                                    input int i);
    return pcd_fn_e'(v[2*i +: 2]);
  endfunction

  always_comb
  begin
    pc_m_d = pc_in;
    pc_s_d = pc_m_q;
    pd_m_d = pd_in;
    pd_s_d = pd_m_q;
    ale_prev_d = pd_s_q[PCD_BIT_ALE];
    lat_addr_d = lat_addr_q;
    // strobe falling edge latches the bus address
    if (fn_of(pd_fn, PCD_BIT_ALE) == PCD_FN_ALT && ale_prev_q
        && !pd_s_q[PCD_BIT_ALE])
      lat_addr_d = bus_addr;
    rel_addr = bus_addr - register_window_base;
    hit_d = (bus_addr >= register_window_base) &&
            (rel_addr < PCD_ADDR_W'(PCD_WIN_BYTES));
    off_d = rel_addr[PCD_WIN_AW-1:0];
  end

  // per-pin routing
  for (genvar i = 0; i < PORT_W; i++)
  begin : g_pin
    always_comb
    begin
      logic c_drv;
      logic c_val;
      c_drv = 1'b0;
      c_val = pc_data_out[i];
      // stby pin carries supply only, so no logic value is passed on
      pc_din_d[i] = (i == PCD_BIT_STBY && fn_of(pc_fn, i) == PCD_FN_ALT)
                    ? 1'b0 : pc_s_q[i];
      pc_pld_d[i] = (fn_of(pc_fn, i) == PCD_FN_PLD) ? pc_s_q[i] : 1'b0;
      case (fn_of(pc_fn, i))
        PCD_FN_MCU: c_drv = pc_dir_out[i];
        PCD_FN_ALT:
        begin
          if (i == PCD_BIT_STAT)
          begin
            c_drv = 1'b1;
            c_val = jtag_prog_status_out;
          end
          else if (i == PCD_BIT_ERR)
          begin
            c_drv = jtag_enable;
            c_val = jtag_prog_error_out;
          end
          else if (i == PCD_BIT_TDO)
          begin
            c_drv = jtag_enable;
            c_val = jtag_tdo;
          end
        end
        PCD_FN_ALT2:
        begin
          if (i == PCD_BIT_STAT)
          begin
            c_drv = 1'b1;
            c_val = flash_ready;
          end
          else if (i == PCD_BIT_ERR)
          begin
            c_drv = 1'b1;
            c_val = on_battery;
          end
        end
        default: c_drv = 1'b0;
      endcase
      // open drain drives only low
      if (pc_open_drain[i])
      begin
        pc_out_d[i] = 1'b0;
        pc_oe_d[i] = c_drv && !c_val;
      end
      else
      begin
        pc_out_d[i] = c_val;
        pc_oe_d[i] = c_drv;
      end
      pd_din_d[i] = pd_s_q[i];
      pd_pld_d[i] = (fn_of(pd_fn, i) == PCD_FN_PLD) ? pd_s_q[i] : 1'b0;
      pd_out_d[i] = pd_data_out[i];
      pd_oe_d[i] = (fn_of(pd_fn, i) == PCD_FN_MCU) && pd_dir_out[i];
    end
  end

  // alternate inputs; inactive levels when not selected, except mem_enable, which goes high (memories enabled)
  always_comb
  begin
    tdi_d = (fn_of(pc_fn, PCD_BIT_TDI) == PCD_FN_ALT && jtag_enable)
            ? pc_s_q[PCD_BIT_TDI] : 1'b0;
    // active-low enable idles high so an unused pin never qualifies a byte
    be_d = (fn_of(pc_fn, PCD_BIT_BE) == PCD_FN_ALT)
           ? pc_s_q[PCD_BIT_BE] : 1'b1;
    clk_d = (fn_of(pd_fn, PCD_BIT_CLK) == PCD_FN_ALT)
            ? pd_s_q[PCD_BIT_CLK] : 1'b0;
    men_d = (fn_of(pd_fn, PCD_BIT_CS) == PCD_FN_ALT)
            ? !pd_s_q[PCD_BIT_CS] : 1'b1;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pc_m_q <= '0; pc_s_q <= '0; pd_m_q <= '0; pd_s_q <= '0;
      ale_prev_q <= 1'b0;
      lat_addr_q <= '0;
      pc_out_q <= '0; pc_oe_q <= '0;
      pd_out_q <= '0; pd_oe_q <= '0;
      pc_din_q <= '0; pd_din_q <= '0; pc_pld_q <= '0; pd_pld_q <= '0;
      tdi_q <= 1'b0; be_q <= 1'b1; clk_q <= 1'b0; men_q <= 1'b0;
      hit_q <= 1'b0; off_q <= '0;
      pa_a_q <= '0; pb_a_q <= '0; pa_e_q <= '0; pb_e_q <= '0;
    end
    else
    begin
      pc_m_q <= pc_m_d; pc_s_q <= pc_s_d; pd_m_q <= pd_m_d; pd_s_q <= pd_s_d;
      ale_prev_q <= ale_prev_d;
      lat_addr_q <= lat_addr_d;
      pc_out_q <= pc_out_d; pc_oe_q <= pc_oe_d;
      pd_out_q <= pd_out_d; pd_oe_q <= pd_oe_d;
      pc_din_q <= pc_din_d; pd_din_q <= pd_din_d;
      pc_pld_q <= pc_pld_d; pd_pld_q <= pd_pld_d;
      tdi_q <= tdi_d; be_q <= be_d; clk_q <= clk_d; men_q <= men_d;
      hit_q <= hit_d; off_q <= off_d;
      pa_a_q <= pa_a_d; pb_a_q <= pb_a_d; pa_e_q <= pa_e_d; pb_e_q <= pb_e_d;
    end
  end

  assign pc_out = pc_out_q;
  assign pc_oe = pc_oe_q;
  assign pd_out = pd_out_q;
  assign pd_oe = pd_oe_q;
  assign pc_data_in = pc_din_q;
  assign pd_data_in = pd_din_q;
  assign pc_pld_in = pc_pld_q;
  assign pd_pld_in = pd_pld_q;
  assign jtag_tdi = tdi_q;
  assign byte_enable_n = be_q;
  assign aux_clock_input = clk_q;
  assign mem_enable = men_q;
  assign window_hit = hit_q;
  assign window_offset = off_q;
  assign pa_addr_out = pa_a_q;
  assign pb_addr_out = pb_a_q;
  assign pa_addr_en = pa_e_q;
  assign pb_addr_en = pb_e_q;

  sequence s_cs_high;
    fn_of(pd_fn, PCD_BIT_CS) == PCD_FN_ALT && pd_s_q[PCD_BIT_CS];
  endsequence

  chk_cs_gates_mem: assert property (@(posedge clock) disable iff (!rstn)
    s_cs_high |=> !mem_enable)
    else $error("memories enabled while chip select high");
  chk_mcu_input_oe: assert property (@(posedge clock) disable iff (!rstn)
    (fn_of(pd_fn, 3) == PCD_FN_MCU && !pd_dir_out[3]) |=> !pd_oe[3])
    else $error("input pin driven");
  chk_od_never_high: assert property (@(posedge clock) disable iff (!rstn)
    $past(pc_open_drain[0]) |-> !(pc_oe[0] && pc_out[0]))
    else $error("open drain pin driven high");
  chk_batt_follow: assert property (@(posedge clock) disable iff (!rstn)
    (fn_of(pc_fn, PCD_BIT_ERR) == PCD_FN_ALT2 && !pc_open_drain[PCD_BIT_ERR])
    |=> pc_oe[PCD_BIT_ERR] && pc_out[PCD_BIT_ERR] == $past(on_battery))
    else $error("battery indicator wrong");
  chk_stat_drive: assert property (@(posedge clock) disable iff (!rstn)
    (fn_of(pc_fn, PCD_BIT_STAT) == PCD_FN_ALT2 && !pc_open_drain[PCD_BIT_STAT])
    |=> pc_out[PCD_BIT_STAT] == $past(flash_ready))
    else $error("ready/busy not driven");
  chk_tdi_gate: assert property (@(posedge clock) disable iff (!rstn)
    !jtag_enable |=> !jtag_tdi)
    else $error("tdi passed while jtag off");
  chk_win_hit: assert property (@(posedge clock) disable iff (!rstn)
    (bus_addr == register_window_base + 16'h0100) |=> !window_hit)
    else $error("window larger than 256 bytes");
  chk_ale_latch: assert property (@(posedge clock) disable iff (!rstn)
    (fn_of(pd_fn, PCD_BIT_ALE) == PCD_FN_ALT && ale_prev_q
     && !pd_s_q[PCD_BIT_ALE]) |=> lat_addr_q == $past(bus_addr))
    else $error("address not latched on strobe");
endmodule // pcd_pin_mux

// [sim/pcd_pin_model.sv]
`timescale 1ns/10ps
// far side of the pins: board drivers plus the block's own drivers
module pcd_pin_model
(
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe,
  input wire logic [7:0] pd_out,
  input wire logic [7:0] pd_oe,
  input wire logic [7:0] pc_ext,
  input wire logic [7:0] pd_ext,
  output logic [7:0] pc_in,
  output logic [7:0] pd_in
);
  // enabled block driver wins, else the board level shows
  assign pc_in = (pc_oe & pc_out) | (~pc_oe & pc_ext);
  assign pd_in = (pd_oe & pd_out) | (~pd_oe & pd_ext);
endmodule // pcd_pin_model

// [sim/port_cd_function_mux_tb_top.sv]
`timescale 1ns/10ps
module port_cd_function_mux_tb_top;
  import pcd_pkg::*;
  logic clock, rstn, jen, jst, jer, tdo, frdy, batt, tdi, ben, aclk, men, hit;
  logic [15:0] pc_fn, pd_fn, addr, base, a0;
  logic [7:0] pc_od, pc_dir, pd_dir, pc_do, pd_do, pc_x, pd_x, pc_in, pd_in;
  logic [7:0] pc_out, pc_oe, pd_out, pd_oe, pc_di, pd_di, pc_pl, pd_pl;
  logic [7:0] pa_a, pb_a, pa_e, pb_e, woff, eo, ee, off;
  logic [1:0] hm;
  int mismatches, cmp_count;

  pcd_pin_mux i_pcd_pin_mux (.clock(clock), .rstn(rstn), .pc_fn(pc_fn),
    .pd_fn(pd_fn), .pc_open_drain(pc_od), .pc_dir_out(pc_dir),
    .pd_dir_out(pd_dir), .pc_data_out(pc_do), .pd_data_out(pd_do),
    .host_mode(hm), .jtag_enable(jen), .jtag_prog_status_out(jst),
    .jtag_prog_error_out(jer), .jtag_tdo(tdo), .flash_ready(frdy),
    .on_battery(batt), .bus_addr(addr), .register_window_base(base),
    .pc_in(pc_in), .pd_in(pd_in), .pc_out(pc_out), .pc_oe(pc_oe),
    .pd_out(pd_out), .pd_oe(pd_oe), .pc_data_in(pc_di), .pd_data_in(pd_di),
    .pc_pld_in(pc_pl), .pd_pld_in(pd_pl), .jtag_tdi(tdi),
    .byte_enable_n(ben), .aux_clock_input(aclk), .mem_enable(men),
    .window_hit(hit), .window_offset(woff), .pa_addr_out(pa_a),
    .pb_addr_out(pb_a), .pa_addr_en(pa_e), .pb_addr_en(pb_e));

  pcd_pin_model i_pcd_pin_model (.pc_out(pc_out), .pc_oe(pc_oe),
    .pd_out(pd_out), .pd_oe(pd_oe), .pc_ext(pc_x), .pd_ext(pd_x),
    .pc_in(pc_in), .pd_in(pd_in));

  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // pins pass two sync flops and an output flop: five cycles is ample
  task automatic settle();
    repeat (5) @(negedge clock);
  endtask

  function automatic logic [31:0] amap(input logic [1:0] m,
                                       input logic [15:0] a);
    case (m)
      2'b00: amap = {8'h0F, 4'h0, a[3:0], 8'hFF, a[7:0]};
      2'b01: amap = {8'hF0, a[7:4], 4'h0, 8'h0F, 4'h0, a[11:8]};
      2'b10: amap = {16'h0000, 8'hFF, a[15:8]};
      default: amap = {16'h0000, 8'hFF, a[7:0]};
    endcase
  endfunction

  task automatic final_report();
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    #200000;
    mismatches++;
    final_report();
  end

  initial
  begin
    {jen, jst, jer, tdo, frdy, batt, hm} = '0;
    {pc_fn, pd_fn, addr, base} = '0;
    {pc_od, pc_dir, pd_dir, pc_do, pd_do, pc_x, pd_x} = '0;
    rstn = 1'b0;
    void'($urandom(96));
    repeat (5) @(negedge clock);
    check("rst_oe", {pc_oe, pd_oe, 7'h00, ben}, 32'h0000_0001);
    rstn = 1'b1;
    settle();
    check("idle_oe", {pc_oe, pd_oe}, 32'h0000_0000);
    repeat (20)
    begin
      {pc_dir, pc_do, pc_od, pc_x} = $urandom;
      {pd_dir, pd_do, pd_x} = 24'($urandom);
      settle();
      eo = pc_dir & ~(pc_od & pc_do);
      ee = pc_do & ~pc_od & eo;
      check("pc_oe", pc_oe, eo);
      check("pc_out", pc_out & eo, ee);
      check("pc_data_in", pc_di, ee | (~eo & pc_x));
      check("pd_oe", pd_oe, pd_dir);
      check("pd_data_in", pd_di, (pd_dir & pd_do) | (~pd_dir & pd_x));
      check("pld_idle", {pc_pl, pd_pl}, 32'h0000_0000);
    end
    {pc_fn, pd_fn, pc_dir, pd_dir} = {16'h5555, 16'h5555, 16'hFFFF};
    {pc_x, pd_x} = 16'($urandom);
    settle();
    check("pld_oe", {pc_oe, pd_oe}, 32'h0000_0000);
    check("pld_in", {pc_pl, pd_pl}, {pc_x, pd_x});
    {pc_fn, pd_fn, pc_dir, pd_dir, pc_od} = {32'hAAA0_0000, 24'h00_0000};
    for (int i = 0; i < 8; i++)
    begin
      jen = i[0];
      {jst, jer, tdo, pc_x} = 11'($urandom);
      settle();
      eo = {1'b0, jen, 1'b0, jen, 4'h8};
      ee = {1'b0, tdo, 1'b0, jer, jst, 3'b000} & eo;
      check("alt_oe", pc_oe, eo);
      check("alt_out", pc_out & eo, ee);
      check("dbe", ben, pc_x[7]);
      check("stby_din", pc_di[2], 1'b0);
      if (jen)
        check("tdi", tdi, pc_x[5]);
      else
        check("tdi_off", tdi, 1'b0);
    end
    pc_fn = 16'h03C0;
    for (int i = 0; i < 4; i++)
    begin
      {frdy, batt} = i[1:0];
      settle();
      check("alt2_oe", pc_oe, 8'h18);
      check("alt2_out", pc_out & 8'h18, {3'b000, batt, frdy, 3'b000});
      check("dbe_idle", ben, 1'b1);
    end
    pd_fn = 16'h002A;
    repeat (8)
    begin
      pd_x = 8'($urandom);
      settle();
      check("pd_alt_oe", pd_oe, 8'h00);
      check("clk_cs", {aclk, men}, {pd_x[1], ~pd_x[2]});
    end
    pd_fn = 16'h0002;
    settle();
    check("no_cs", men, 1'b1);
    for (int m = 0; m < 4; m++)
    begin
      hm = m[1:0];
      a0 = 16'($urandom);
      addr = a0;
      pd_x = 8'h01;
      settle();
      pd_x = 8'h00;
      settle();
      check("lat", {pa_e, pa_a & pa_e, pb_e, pb_a & pb_e}, amap(hm, a0));
      addr = ~a0;
      settle();
      check("hold", {pa_e, pa_a & pa_e, pb_e, pb_a & pb_e}, amap(hm, a0));
    end
    pd_fn = 16'h0000;
    base = {8'($urandom_range(255, 1)), 8'h00};
    repeat (8)
    begin
      off = 8'($urandom);
      addr = base + 16'(off);
      settle();
      check("win_in", {hit, woff}, {1'b1, off});
      addr = base - 16'h0001;
      settle();
      check("win_out", hit, 1'b0);
    end
    {pc_dir, pd_dir, pc_od} = 24'hFF_FF00;
    settle();
    rstn = 1'b0;
    #2;
    check("mid_rst", {pc_oe, pd_oe, 7'h00, ben}, 32'h0000_0001);
    @(negedge clock);
    rstn = 1'b1;
    settle();
    check("rerun_oe", {pc_oe, pd_oe}, 32'h0000_FFFF);
    final_report();
  end
endmodule // port_cd_function_mux_tb_top
